// ==== hdl/pbs_pkg.sv ====
// Purpose: shared constants and types of the pushbutton power sequencer
// Assumes: 250 MHz system clock, 1 ms internal timebase
// Notes:   timing figures are kept as printed, cycle counts derived here

package pbs_pkg;

    ////////////////////////////////////////////////////////////////////////
    // clock and timebase
    localparam int CLK_PERIOD_PS = 4000;
    localparam int TICK_NS = 1000000;
    // cycles per 1 ms tick, exact division
    localparam int TICK_CYC_DEF = TICK_NS * 1000 / CLK_PERIOD_PS;

    ////////////////////////////////////////////////////////////////////////
    // sequence times in ms (one tick each)
    localparam int DB_MS = 32;
    localparam int BLANK_MS = 512;
    localparam int PDOWN_MS = 1024;
    localparam int LOCK_MS = 256;

    // least cut-input low time; a least time rounds up
    localparam int KILL_PW_NS = 30000;
    localparam int KILL_CYC_DEF =
        (KILL_PW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    ////////////////////////////////////////////////////////////////////////
    // widths
    localparam int CNT_W = 16;
    localparam int EXT_W_DEF = 8;

    // timer end values, counted in ticks from zero
    localparam logic [CNT_W-1:0] DB_TGT = 16'h0020;
    localparam logic [CNT_W-1:0] BLANK_END = CNT_W'(BLANK_MS - 1);
    localparam logic [CNT_W-1:0] PDOWN_END = CNT_W'(PDOWN_MS - 1);
    localparam logic [CNT_W-1:0] LOCK_END = CNT_W'(LOCK_MS - 1);

    ////////////////////////////////////////////////////////////////////////
    // sequencer states
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,   // off, waiting for a press
        ST_BLANK = 7'h02,  // on, cut input and button ignored
        ST_RELDB = 7'h04,  // on, debouncing button release
        ST_ON = 7'h08,     // on, watching for turn-off press
        ST_PDOWN = 7'h10,  // shutdown request low, timer runs
        ST_LOCK = 7'h20,   // off, button locked out
        ST_OFFREL = 7'h40  // off, debouncing button release
    } pbs_state_t;

    // open-drain pin: out value and enable (high while pulling)
    typedef struct packed {
        logic out;
        logic oe;
    } pbs_od_t;

    // whole state of the sequencer
    typedef struct packed {
        pbs_state_t st;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] klo;
        logic kill_low;
        logic en_on;
        pbs_od_t pwr;
        pbs_od_t req;
    } pbs_regs_t;

    // reset values; positive variant pulls its output low when off
    localparam pbs_regs_t PBS_RST_POS = '{st: ST_IDLE, cnt: 16'h0000,
        klo: 16'h0000, kill_low: 1'b0, en_on: 1'b0,
        pwr: '{out: 1'b0, oe: 1'b1}, req: '{out: 1'b0, oe: 1'b0}};
    localparam pbs_regs_t PBS_RST_NEG = '{st: ST_IDLE, cnt: 16'h0000,
        klo: 16'h0000, kill_low: 1'b0, en_on: 1'b0,
        pwr: '{out: 1'b0, oe: 1'b0}, req: '{out: 1'b0, oe: 1'b0}};

endpackage : pbs_pkg

// ==== hdl/pbs_tick.sv ====
// Purpose: divider making the one-cycle 1 ms timebase enable
// Assumes: CYC system cycles per tick
// Notes:   free running from reset release

`timescale 1ns/1ps

module pbs_tick import pbs_pkg::*; #(
    parameter int CYC = TICK_CYC_DEF
) (
    input wire logic clock,
    input wire logic rst_b,
    output logic tick
);

    localparam int CW = $clog2(CYC);

    typedef struct packed {
        logic [CW-1:0] div;
        logic tick;
    } pbs_tick_t;

    pbs_tick_t r;
    pbs_tick_t next_r;

    generate
        if (CYC < 2) begin : g_bad_cyc
            $error("pbs_tick: CYC must be at least 2");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // count down, pulse when wrapping
    always_comb begin
        next_r = r;
        next_r.tick = (r.div == '0);
        if (r.div == '0) begin
            next_r.div = CW'(CYC - 1);
        end else begin
            next_r.div = r.div - 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign tick = r.tick;

endmodule : pbs_tick

// ==== hdl/pbs_sequencer.sv ====
// Purpose: pushbutton on/off power sequencer with processor handshake
// Assumes: all inputs synchronous to clock; 1 ms internal timebase
// Notes:   open-drain pins appear as out/oe pairs, oe high while pulling
//
// Behaviour
// - reset leaves converter off: positive variant pulls power output low, negative releases it
// - turn on after 32 ms plus extension low
// - button high during turn-on resets timer
// - no extension means a 32 to 33 ms debounce (33 ticks)
// - power-on assertion starts 512 ms blanking timer
// - blanking ignores cut input and button
// - cut input low at blanking end aborts
// - debounce button release 32 ms after blanking, power-off
// - turn-off after 32 ms plus extension low
// - button high during turn-off resets timer
// - valid turn-off lowers request, starts 1024 ms
// - power-down timeout with cut high releases output
// - cut low in power-down releases, cancels timer
// - cut low after blanking releases power output
// - open drain output, polarity chosen by variant
// - after power-off wait for new press
// - 256 ms button lockout after cut release
// - cut input low must last 30 us

`timescale 1ns/1ps

module pbs_sequencer import pbs_pkg::*; #(
    parameter bit NEG_EN = 1'b0,
    parameter int EXT_W = EXT_W_DEF,
    parameter int TICK_CYC = TICK_CYC_DEF,
    parameter int KILL_CYC = KILL_CYC_DEF
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic push_button_n,
    input wire logic kill_n,
    input wire logic [EXT_W-1:0] on_time_extend,
    input wire logic [EXT_W-1:0] off_time_extend,
    output pbs_od_t power_on,
    output pbs_od_t shutdown_req_n
);

    localparam pbs_regs_t REGS_RST = NEG_EN ? PBS_RST_NEG : PBS_RST_POS;
    localparam logic [CNT_W-1:0] KILL_END = CNT_W'(KILL_CYC - 1);

    pbs_regs_t r;
    pbs_regs_t next_r;
    logic tick;
    logic [CNT_W-1:0] on_tgt;
    logic [CNT_W-1:0] off_tgt;

    ////////////////////////////////////////////////////////////////////////
    // parameter checks; counters are 16 bits wide
    generate
        if (EXT_W < 1 || EXT_W > 14) begin : g_bad_ext
            $error("pbs_sequencer: EXT_W must be 1 to 14");
        end
        if (KILL_CYC < 1 || KILL_CYC > 65535) begin : g_bad_kill
            $error("pbs_sequencer: KILL_CYC must be 1 to 65535");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // timebase
    pbs_tick #(
        .CYC(TICK_CYC)
    ) u_tick (
        .clock(clock),
        .rst_b(rst_b),
        .tick(tick)
    );

    // debounce targets: fixed 32 ticks plus extension ticks
    assign on_tgt = DB_TGT + CNT_W'(on_time_extend);
    assign off_tgt = DB_TGT + CNT_W'(off_time_extend);

    ////////////////////////////////////////////////////////////////////////
    // release power and the request, move to an off state
    function automatic pbs_regs_t power_off(input pbs_regs_t cur,
                                            input pbs_state_t to);
        pbs_regs_t res;
        res = cur;
        res.st = to;
        res.cnt = '0;
        res.en_on = 1'b0;
        res.req.oe = 1'b0;
        return res;
    endfunction : power_off

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        next_r = r;
        // cut input filter: act only on a low held KILL_CYC samples
        if (kill_n) begin
            next_r.klo = '0;
        end else if (r.klo != KILL_END) begin
            next_r.klo = r.klo + 1'b1;
        end
        next_r.kill_low = !kill_n && (r.klo == KILL_END);

        case (r.st)
            ST_IDLE: begin
                // timer counts only while the press is unbroken
                if (push_button_n) begin
                    next_r.cnt = '0;
                end else if (tick) begin
                    if (r.cnt == on_tgt) begin
                        next_r.st = ST_BLANK;
                        next_r.cnt = '0;
                        next_r.en_on = 1'b1;
                    end else begin
                        next_r.cnt = r.cnt + 1'b1;
                    end
                end
            end
            ST_BLANK: begin
                // neither input is looked at until the last tick
                if (tick) begin
                    if (r.cnt != BLANK_END) begin
                        next_r.cnt = r.cnt + 1'b1;
                    end else if (r.kill_low) begin
                        next_r = power_off(r, ST_LOCK);
                    end else begin
                        next_r.st = ST_RELDB;
                        next_r.cnt = '0;
                    end
                end
            end
            ST_RELDB: begin
                if (r.kill_low) begin
                    next_r = power_off(r, ST_LOCK);
                end else if (!push_button_n) begin
                    next_r.cnt = '0;
                end else if (tick) begin
                    if (r.cnt == DB_TGT) begin
                        next_r.st = ST_ON;
                        next_r.cnt = '0;
                    end else begin
                        next_r.cnt = r.cnt + 1'b1;
                    end
                end
            end
            ST_ON: begin
                if (r.kill_low) begin
                    next_r = power_off(r, ST_LOCK);
                end else if (push_button_n) begin
                    next_r.cnt = '0;
                end else if (tick) begin
                    if (r.cnt == off_tgt) begin
                        next_r.st = ST_PDOWN;
                        next_r.cnt = '0;
                        next_r.req.oe = 1'b1;
                    end else begin
                        next_r.cnt = r.cnt + 1'b1;
                    end
                end
            end
            ST_PDOWN: begin
                // host answer wins over the timeout
                if (r.kill_low) begin
                    next_r = power_off(r, ST_LOCK);
                end else if (tick) begin
                    if (r.cnt == PDOWN_END) begin
                        next_r = power_off(r, ST_OFFREL);
                    end else begin
                        next_r.cnt = r.cnt + 1'b1;
                    end
                end
            end
            ST_LOCK: begin
                // button ignored while the supply decays
                if (tick) begin
                    if (r.cnt == LOCK_END) begin
                        next_r.st = ST_OFFREL;
                        next_r.cnt = '0;
                    end else begin
                        next_r.cnt = r.cnt + 1'b1;
                    end
                end
            end
            ST_OFFREL: begin
                // a held button must go high before a new press counts
                if (!push_button_n) begin
                    next_r.cnt = '0;
                end else if (tick) begin
                    if (r.cnt == DB_TGT) begin
                        next_r.st = ST_IDLE;
                        next_r.cnt = '0;
                    end else begin
                        next_r.cnt = r.cnt + 1'b1;
                    end
                end
            end
            default: begin
                next_r = REGS_RST;
            end
        endcase

        // open-drain pins: positive variant pulls low when off
        next_r.pwr.out = 1'b0;
        next_r.pwr.oe = NEG_EN ? next_r.en_on : !next_r.en_on;
        next_r.req.out = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // state register; reset holds the converter off
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            r <= REGS_RST;
        end else begin
            r <= next_r;
        end
    end

    assign power_on = r.pwr;
    assign shutdown_req_n = r.req;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    pwr_polarity_a: assert property (
        power_on.oe == (NEG_EN ? r.en_on : !r.en_on) && !power_on.out)
        else $error("power output enable does not match variant");

    on_debounce_a: assert property (
        r.st == ST_IDLE && tick && !push_button_n && r.cnt == on_tgt
        |=> r.en_on && r.st == ST_BLANK && r.cnt == 16'h0000)
        else $error("power not asserted after turn-on debounce");

    press_reset_a: assert property (
        r.st == ST_IDLE && push_button_n |=> r.cnt == 16'h0000 && !r.en_on)
        else $error("turn-on timer not cleared by button high");

    blank_hold_a: assert property (
        r.st == ST_BLANK && !(tick && r.cnt == BLANK_END)
        |=> r.st == ST_BLANK && r.en_on)
        else $error("blanking window left early");

    blank_abort_a: assert property (
        r.st == ST_BLANK && tick && r.cnt == BLANK_END && r.kill_low
        |=> !r.en_on ##1 power_on.oe == !NEG_EN)
        else $error("power not released at blanking end");

    turnoff_req_a: assert property (
        r.st == ST_ON && !r.kill_low && tick && !push_button_n
        && r.cnt == off_tgt |=> shutdown_req_n.oe && r.st == ST_PDOWN)
        else $error("shutdown request not raised");

    pdown_timeout_a: assert property (
        r.st == ST_PDOWN && !r.kill_low && tick && r.cnt == PDOWN_END
        |=> r.st == ST_OFFREL && !r.en_on && !shutdown_req_n.oe)
        else $error("power-down timeout did not release power");

    kill_release_a: assert property (
        r.kill_low && (r.st == ST_PDOWN || r.st == ST_ON)
        |=> r.st == ST_LOCK && !r.en_on && r.cnt == 16'h0000)
        else $error("cut input did not release power");

    kill_glitch_a: assert property (
        $rose(r.kill_low) |-> $past(r.klo) == KILL_END && !$past(kill_n))
        else $error("cut input acted on before minimum width");

    lock_ignore_a: assert property (
        r.st == ST_LOCK && !(tick && r.cnt == LOCK_END)
        |=> r.st == ST_LOCK && !r.en_on)
        else $error("lockout left early");

    req_only_pdown_a: assert property (
        shutdown_req_n.oe |-> r.st == ST_PDOWN && r.en_on)
        else $error("shutdown request low outside power-down");

    // a turn-on tick below the fixed count must never leave idle
    early_on_a: assert property (
        r.st == ST_IDLE && tick && r.cnt < DB_TGT |=> r.st == ST_IDLE)
        else $error("power asserted before fixed debounce");

    reldb_restart_a: assert property (
        r.st == ST_RELDB && !r.kill_low && !push_button_n
        |=> r.st == ST_RELDB && r.cnt == 16'h0000)
        else $error("release debounce not restarted by press");

    reldb_kill_a: assert property (
        r.kill_low && r.st == ST_RELDB
        |=> r.st == ST_LOCK && !r.en_on && power_on.oe == !NEG_EN)
        else $error("cut input ignored during release debounce");

    offrel_wait_a: assert property (
        r.st == ST_OFFREL && !push_button_n
        |=> r.st == ST_OFFREL && r.cnt == 16'h0000 && !r.en_on)
        else $error("held button counted as a new press");

    turnoff_reset_a: assert property (
        r.st == ST_ON && !r.kill_low && push_button_n
        |=> r.st == ST_ON && r.cnt == 16'h0000)
        else $error("turn-off timer not cleared by button high");

endmodule : pbs_sequencer

// ==== testbench/pbs_host_model.sv ====
// Purpose: behavioural host processor on the cut-input side of the sequencer
// Assumes: pin levels already resolved from the open-drain enables
// Notes:   an unpowered host leaves the cut input low

`timescale 1ns/1ps

module pbs_host_model #(
    parameter int RAISE_DLY = 400,
    parameter int LOWER_DLY = 24,
    parameter int GLITCH_CYC = 2
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic power_pin,
    input wire logic req_pin,
    input wire logic raise_en,
    input wire logic lower_en,
    input wire logic glitch,
    input wire logic cut,
    output logic kill_n
);
    int cnt;
    int gl;

    ////////////////////////////////////////////////////////////////////////
    // host boot, housekeeping and a short glitch when commanded
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            kill_n <= 1'b0;
            cnt <= 0;
            gl <= 0;
        end else if (!power_pin) begin
            kill_n <= 1'b0; // no supply, no drive
            cnt <= 0;
            gl <= 0;
        end else if (gl != 0) begin
            gl <= gl - 1;
            if (gl == 1) begin
                kill_n <= 1'b1;
            end
        end else if (cut) begin
            kill_n <= 1'b0; // host drops power while running
            cnt <= 0;
        end else if (glitch) begin
            kill_n <= 1'b0; // shorter than the filter accepts
            gl <= GLITCH_CYC;
        end else if (!kill_n && raise_en) begin
            if (cnt == RAISE_DLY) begin
                kill_n <= 1'b1;
                cnt <= 0;
            end else begin
                cnt <= cnt + 1;
            end
        end else if (kill_n && !req_pin && lower_en) begin
            if (cnt == LOWER_DLY) begin
                kill_n <= 1'b0;
                cnt <= 0;
            end else begin
                cnt <= cnt + 1;
            end
        end
    end
endmodule : pbs_host_model

// ==== testbench/pushbutton_power_sequencer_tb_top.sv ====
// Purpose: self-checking bench for the pushbutton power sequencer
// Assumes: positive variant, short tick so the long timers stay cheap
// Notes:   expected pin changes are queued with a window of cycles

`timescale 1ns/1ps

module pushbutton_power_sequencer_tb_top import pbs_pkg::*;;
    localparam int T = 4;
    localparam int KC = 2;
    typedef struct {logic [1:0] v; int lo; int hi;} pbs_note_t;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic push_button_n = 1'b1;
    logic raise_en = 1'b0;
    logic lower_en = 1'b0;
    logic glitch = 1'b0;
    logic cut = 1'b0;
    logic [7:0] on_ext = 8'h00;
    logic [7:0] off_ext = 8'h00;
    pbs_od_t power_on;
    pbs_od_t shutdown_req_n;
    pbs_od_t neg_on;
    pbs_od_t neg_req;
    logic kill_n;
    int cyc = 0;
    int t0 = 0;
    int num_errors = 0;
    int n_checks = 0;
    int seed = 32'hde2f5003;
    pbs_note_t notes[$];
    // converter and host hold pull-ups on both pins
    wire pwr_pin = power_on.oe ? power_on.out : 1'b1;
    wire req_pin = shutdown_req_n.oe ? shutdown_req_n.out : 1'b1;
    wire [1:0] pins = {pwr_pin, req_pin};

    always #2 clock = ~clock;
    always @(posedge clock) cyc <= cyc + 1;

    pbs_sequencer #(.NEG_EN(1'b0), .EXT_W(8), .TICK_CYC(T), .KILL_CYC(KC))
    DUT (.clock(clock), .rst_b(rst_b), .push_button_n(push_button_n),
        .kill_n(kill_n), .on_time_extend(on_ext),
        .off_time_extend(off_ext), .power_on(power_on),
        .shutdown_req_n(shutdown_req_n));

    // negative variant on the same stimulus: only the polarity may differ
    pbs_sequencer #(.NEG_EN(1'b1), .EXT_W(8), .TICK_CYC(T), .KILL_CYC(KC))
    DUT_NEG (.clock(clock), .rst_b(rst_b), .push_button_n(push_button_n),
        .kill_n(kill_n), .on_time_extend(on_ext),
        .off_time_extend(off_ext), .power_on(neg_on),
        .shutdown_req_n(neg_req));

    // glitch one sample shorter than the filter accepts
    pbs_host_model #(.RAISE_DLY(400), .LOWER_DLY(24), .GLITCH_CYC(KC - 1))
    host (.clock(clock), .rst_b(rst_b), .power_pin(pwr_pin),
        .req_pin(req_pin), .raise_en(raise_en), .lower_en(lower_en),
        .glitch(glitch), .cut(cut), .kill_n(kill_n));

    ////////////////////////////////////////////////////////////////////////
    // shared helpers
    task check(input string what, input logic [31:0] seen,
            input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task complete_run();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run

    task note(input logic [1:0] v, input int lo, input int hi);
        notes.push_back('{v, lo, hi});
    endtask : note

    task drive(input logic b);
        @(negedge clock);
        push_button_n = b;
        t0 = cyc;
    endtask : drive

    task idle(input int ticks);
        repeat (ticks * T) @(negedge clock);
    endtask : idle

    // press held long enough for n ticks, change expected to v
    task press(input int n, input logic [1:0] v);
        drive(1'b0);
        note(v, t0 + (n - 1) * T, t0 + n * T + 3);
    endtask : press

    task wait_pins(input logic [1:0] v);
        for (int i = 0; i < 20000 && pins !== v; i++) @(negedge clock);
        check("pins reached", pins, v);
        t0 = cyc;
    endtask : wait_pins

    ////////////////////////////////////////////////////////////////////////
    // monitor: every pin change must match the oldest note
    initial begin
        logic [1:0] last;
        pbs_note_t n;
        @(posedge rst_b);
        last = pins;
        forever begin
            @(negedge clock);
            check("negative variant", {neg_on.oe, neg_req.oe},
                {!power_on.oe, shutdown_req_n.oe});
            if (pins !== last) begin
                last = pins;
                if (notes.size() == 0) begin
                    check("unexpected change", 1'b1, 1'b0);
                end else begin
                    n = notes.pop_front();
                    check("pin levels", pins, n.v);
                    check("change time", cyc >= n.lo && cyc <= n.hi,
                        1'b1);
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // watchdog: the run needs about 17000 cycles
    initial begin
        repeat (60000) @(posedge clock);
        check("watchdog", 1'b1, 1'b0);
        complete_run();
    end

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (20) @(negedge clock);
        rst_b = 1'b1;
        @(negedge clock);
        check("reset pins", pins, 2'b01);
        check("od value", {power_on.out, shutdown_req_n.out}, 2'b00);
        on_ext = 8'($random(seed) & 3);
        off_ext = 8'($random(seed) & 3);
        raise_en = 1'b1;
        lower_en = 1'b1;
        // interrupted press must restart the count
        drive(1'b0);
        idle(20);
        drive(1'b1);
        idle(5);
        press(33 + on_ext, 2'b11);
        wait_pins(2'b11);
        // button stays low and host boots late: both ignored
        idle(530);
        drive(1'b1);
        idle(20);
        drive(1'b0); // low during release debounce restarts it
        idle(20);
        drive(1'b1);
        idle(40);
        @(negedge clock);
        glitch = 1'b1;
        @(negedge clock);
        glitch = 1'b0;
        drive(1'b0);
        idle(20);
        drive(1'b1);
        idle(5);
        press(33 + off_ext, 2'b10);
        wait_pins(2'b10);
        for (int i = 0; i < 1000 && kill_n !== 1'b0; i++) @(negedge clock);
        note(2'b01, cyc + 1, cyc + KC + 4);
        wait_pins(2'b01);
        // press inside the lockout must do nothing
        drive(1'b1);
        idle(40);
        drive(1'b0);
        idle(60);
        drive(1'b1);
        idle(200);
        // abort: host never raises the cut input
        raise_en = 1'b0;
        press(33 + on_ext, 2'b11);
        wait_pins(2'b11);
        note(2'b01, t0 + 511 * T, t0 + 512 * T + 3);
        drive(1'b1);
        wait_pins(2'b01);
        idle(300);
        // timeout: host ignores the request, no turn-on extension
        raise_en = 1'b1;
        lower_en = 1'b0;
        on_ext = 8'h00;
        press(33, 2'b11);
        wait_pins(2'b11);
        idle(520);
        drive(1'b1);
        idle(40);
        press(33 + off_ext, 2'b10);
        wait_pins(2'b10);
        note(2'b01, t0 + 1023 * T, t0 + 1024 * T + 3);
        wait_pins(2'b01);
        // no lockout after a timeout, next press turns on
        drive(1'b1);
        idle(40);
        press(33, 2'b11);
        wait_pins(2'b11);
        // host cuts power during normal on operation
        idle(520);
        drive(1'b1);
        idle(40);
        cut = 1'b1;
        for (int i = 0; i < 1000 && kill_n !== 1'b0; i++) @(negedge clock);
        note(2'b01, cyc + 1, cyc + KC + 4);
        wait_pins(2'b01);
        cut = 1'b0;
        idle(5);
        complete_run();
    end
endmodule : pushbutton_power_sequencer_tb_top
